// [hdl/fmd_config_bank.sv]
/*
  fmd_config_bank: five byte-wide configuration registers behind an
  AXI4-Lite slave; fault-report masking, dimming options and fail-safe
  routing of the first four output channels.
  Assumes the nonvolatile copy is valid while reset is held, fault sources
  and fail-safe inputs are synchronous to i_mclk except the fail-safe pins.
*/
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/1ns
`default_nettype none

module fmd_config_bank (
  // clock and reset
  input  wire logic                        i_mclk,
  input  wire logic                        i_resetn,
  // nonvolatile copy
  input  wire fmd_pkg::fmd_nvm_type        i_nvm,
  // axi4-lite write address and data
  input  wire logic                        i_awvalid,
  output logic                             o_awready,
  input  wire logic [fmd_pkg::ADDR_W-1:0]  i_awaddr,
  input  wire logic [2:0]                  i_awprot,
  input  wire logic                        i_wvalid,
  output logic                             o_wready,
  input  wire logic [31:0]                 i_wdata,
  input  wire logic [3:0]                  i_wstrb,
  // axi4-lite write response
  output logic                             o_bvalid,
  input  wire logic                        i_bready,
  output logic [1:0]                       o_bresp,
  // axi4-lite read
  input  wire logic                        i_arvalid,
  output logic                             o_arready,
  input  wire logic [fmd_pkg::ADDR_W-1:0]  i_araddr,
  input  wire logic [2:0]                  i_arprot,
  output logic                             o_rvalid,
  input  wire logic                        i_rready,
  output logic [31:0]                      o_rdata,
  output logic [1:0]                       o_rresp,
  // raw fault events
  input  wire fmd_pkg::fmd_dev_fault_type  i_dev_fault,
  input  wire fmd_pkg::fmd_out_fault_type  i_out_fault,
  // fault reports after masking
  output fmd_pkg::fmd_dev_fault_type       o_dev_report,
  output fmd_pkg::fmd_out_fault_type       o_out_report,
  // dimming options
  output fmd_pkg::fmd_dim_type             o_dim,
  // fail-safe routing
  input  wire logic                        i_failsafe_state,
  input  wire logic                        i_failsafe_input_0,
  input  wire logic                        i_failsafe_input_1,
  output logic                             o_group_a_output_0,
  output logic                             o_group_a_output_1,
  output logic                             o_group_b_output_0,
  output logic                             o_group_b_output_1
);

  typedef struct packed {
    logic [7:0]                 dev_mask;
    logic [7:0]                 out_mask;
    logic [7:0]                 dim_cfg;
    logic [7:0]                 fs_map;
    logic                       aw_held;
    logic [fmd_pkg::ADDR_W-1:0] aw_addr;
    logic                       w_held;
    logic [31:0]                w_data;
    logic                       w_strb0;
    logic                       bvalid;
    logic [1:0]                 bresp;
    logic                       rvalid;
    logic [31:0]                rdata;
    logic [1:0]                 rresp;
    logic [1:0]                 fs0_sync;
    logic [1:0]                 fs1_sync;
    logic                       fs_state_q;
    logic [3:0]                 fs_out;
  } fmd_state_type;

  fmd_state_type state;
  fmd_state_type next_state;

  logic [7:0] wr_idx;
  logic [7:0] rd_idx;
  logic       wr_fire;
  logic [7:0] wbyte;
  logic       fs0;
  logic       fs1;

  assign wr_idx = 8'(state.aw_addr >> fmd_pkg::IDX_LSB);
  assign rd_idx = 8'(i_araddr >> fmd_pkg::IDX_LSB);
  assign wbyte  = state.w_data[7:0];

  // both halves held and the response slot free
  assign wr_fire = state.aw_held && state.w_held && !state.bvalid;

  assign o_awready = !state.aw_held;
  assign o_wready  = !state.w_held;
  assign o_arready = !state.rvalid;
  assign o_bvalid  = state.bvalid;
  assign o_bresp   = state.bresp;
  assign o_rvalid  = state.rvalid;
  assign o_rdata   = state.rdata;
  assign o_rresp   = state.rresp;

  // only the second synchroniser stage is read
  assign fs0 = state.fs0_sync[1];
  assign fs1 = state.fs1_sync[1];

  always_comb begin
    next_state = state;

    // address and data may arrive in either order
    if (i_awvalid && !state.aw_held) begin
      next_state.aw_held = 1'b1;
      next_state.aw_addr = i_awaddr;
    end
    if (i_wvalid && !state.w_held) begin
      next_state.w_held  = 1'b1;
      next_state.w_data  = i_wdata;
      next_state.w_strb0 = i_wstrb[0];
    end

    if (wr_fire) begin
      next_state.aw_held = 1'b0;
      next_state.w_held  = 1'b0;
      next_state.bvalid  = 1'b1;
      next_state.bresp   = fmd_pkg::RESP_OKAY;
      case (wr_idx)
        fmd_pkg::IDX_DEV_MASK: begin
          if (state.w_strb0) begin
            next_state.dev_mask = wbyte & fmd_pkg::WMASK_DEV;
          end
        end
        fmd_pkg::IDX_OUT_MASK: begin
          if (state.w_strb0) begin
            next_state.out_mask = wbyte & fmd_pkg::WMASK_OUT;
          end
        end
        fmd_pkg::IDX_DIM_CFG: begin
          if (state.w_strb0) begin
            next_state.dim_cfg = wbyte & fmd_pkg::WMASK_DIM;
          end
        end
        fmd_pkg::IDX_DIM_RSVD: begin
          next_state.bresp = fmd_pkg::RESP_OKAY; // write dropped
        end
        fmd_pkg::IDX_FS_MAP_AB: begin
          if (state.w_strb0) begin
            next_state.fs_map = wbyte & fmd_pkg::WMASK_FS;
          end
        end
        default: begin
          next_state.bresp = fmd_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (state.bvalid && i_bready) begin
      next_state.bvalid = 1'b0;
    end

    if (i_arvalid && !state.rvalid) begin
      next_state.rvalid = 1'b1;
      next_state.rresp  = fmd_pkg::RESP_OKAY;
      next_state.rdata  = 32'h0000_0000;
      case (rd_idx)
        fmd_pkg::IDX_DEV_MASK: begin
          next_state.rdata[7:0] = state.dev_mask;
        end
        fmd_pkg::IDX_OUT_MASK: begin
          next_state.rdata[7:0] = state.out_mask;
        end
        fmd_pkg::IDX_DIM_CFG: begin
          next_state.rdata[7:0] = state.dim_cfg;
        end
        fmd_pkg::IDX_DIM_RSVD: begin
          next_state.rdata[7:0] = fmd_pkg::DIM_RSVD_VAL;
        end
        fmd_pkg::IDX_FS_MAP_AB: begin
          next_state.rdata[7:0] = state.fs_map;
        end
        default: begin
          next_state.rresp = fmd_pkg::RESP_SLVERR;
        end
      endcase
    end else if (state.rvalid && i_rready) begin
      next_state.rvalid = 1'b0;
    end

    next_state.fs0_sync   = {state.fs0_sync[0], i_failsafe_input_0};
    next_state.fs1_sync   = {state.fs1_sync[0], i_failsafe_input_1};
    next_state.fs_state_q = i_failsafe_state;

    // outputs follow the mapped input only in fail-safe state
    if (state.fs_state_q) begin
      next_state.fs_out[0] = state.fs_map[fmd_pkg::B_FS_A0] ? fs1 : fs0;
      next_state.fs_out[1] = state.fs_map[fmd_pkg::B_FS_A1] ? fs1 : fs0;
      next_state.fs_out[2] = state.fs_map[fmd_pkg::B_FS_B0] ? fs1 : fs0;
      next_state.fs_out[3] = state.fs_map[fmd_pkg::B_FS_B1] ? fs1 : fs0;
    end else begin
      next_state.fs_out = 4'h0;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      state          <= '0;
      // reload from the nonvolatile copy each reset cycle
      state.dev_mask <= i_nvm.dev_mask & fmd_pkg::WMASK_DEV;
      state.out_mask <= i_nvm.out_mask & fmd_pkg::WMASK_OUT;
      state.dim_cfg  <= i_nvm.dim_cfg & fmd_pkg::WMASK_DIM;
      state.fs_map   <= i_nvm.fs_map & fmd_pkg::WMASK_FS;
    end else begin
      state <= next_state;
    end
  end

  // masking is combinational so a mask write acts in the next cycle
  always_comb begin
    o_dev_report.supply_low       = i_dev_fault.supply_low
                                    & ~state.dev_mask[fmd_pkg::B_SUP_LOW];
    o_dev_report.supply_uv        = i_dev_fault.supply_uv
                                    & ~state.dev_mask[fmd_pkg::B_SUP_UV];
    o_dev_report.reference_pin    = i_dev_fault.reference_pin
                                    & ~state.dev_mask[fmd_pkg::B_REF_PIN];
    o_dev_report.thermal_prewarn  = i_dev_fault.thermal_prewarn
                                    & ~state.dev_mask[fmd_pkg::B_PREWARN];
    o_dev_report.thermal_shutdown = i_dev_fault.thermal_shutdown
                                    & ~state.dev_mask[fmd_pkg::B_TSD];
    o_dev_report.nvm_checksum     = i_dev_fault.nvm_checksum
                                    & ~state.dev_mask[fmd_pkg::B_NVM_CRC];
    o_out_report.open_circuit     = i_out_fault.open_circuit
                                    & {4{~state.out_mask[fmd_pkg::B_OPEN]}};
    o_out_report.short_circuit    = i_out_fault.short_circuit
                                    & {4{~state.out_mask[fmd_pkg::B_SHORT]}};
    o_out_report.single_led_short = i_out_fault.single_led_short
                                    & {4{~state.out_mask[fmd_pkg::B_SLS]}};
  end

  always_comb begin
    o_dim.exponential_curve_enable     = state.dim_cfg[fmd_pkg::B_EXP];
    o_dim.phase_shift_enable           = state.dim_cfg[fmd_pkg::B_PHASE];
    o_dim.twelve_bit_resolution_enable = state.dim_cfg[fmd_pkg::B_TWELVE];
    o_dim.power_save_enable            = state.dim_cfg[fmd_pkg::B_PSAVE];
    o_dim.pwm_frequency_code           =
      state.dim_cfg[fmd_pkg::B_FREQ_HI:fmd_pkg::B_FREQ_LO];
  end

  assign o_group_a_output_0 = state.fs_out[0];
  assign o_group_a_output_1 = state.fs_out[1];
  assign o_group_b_output_0 = state.fs_out[2];
  assign o_group_b_output_1 = state.fs_out[3];

  logic unused_prot;
  assign unused_prot = ^{i_awprot, i_arprot, state.w_data[31:8]};

endmodule

`default_nettype wire

// [hdl/fmd_pkg.sv]
/*
  fmd_pkg: register map, field positions, write masks and carrier structs
  for the fault-mask / dimming / fail-safe configuration bank.
  Assumes a 32-bit AXI4-Lite register bus and byte-wide registers in the
  low bits of each word.
*/
package fmd_pkg;

  // register indices as printed; byte address is index times four
  localparam logic [7:0] IDX_DEV_MASK  = 8'h7c;
  localparam logic [7:0] IDX_OUT_MASK  = 8'h7d;
  localparam logic [7:0] IDX_DIM_CFG   = 8'h7e;
  localparam logic [7:0] IDX_DIM_RSVD  = 8'h7f;
  localparam logic [7:0] IDX_FS_MAP_AB = 8'h80;
  localparam int         ADDR_W        = 10;
  localparam int         IDX_LSB       = 2;

  // writable bits of each register, and the read value of the reserved register
  localparam logic [7:0] WMASK_DEV  = 8'hfc;
  localparam logic [7:0] WMASK_OUT  = 8'h07;
  localparam logic [7:0] WMASK_DIM  = 8'hff;
  localparam logic [7:0] WMASK_FS   = 8'h33;
  localparam logic [7:0] DIM_RSVD_VAL = 8'h00;

  // device fault mask field positions
  localparam int B_SUP_LOW  = 7;
  localparam int B_SUP_UV   = 6;
  localparam int B_REF_PIN  = 5;
  localparam int B_PREWARN  = 4;
  localparam int B_TSD      = 3;
  localparam int B_NVM_CRC  = 2;
  // output fault mask field positions
  localparam int B_OPEN     = 2;
  localparam int B_SHORT    = 1;
  localparam int B_SLS      = 0;
  // dimming config field positions
  localparam int B_EXP      = 7;
  localparam int B_PHASE    = 6;
  localparam int B_TWELVE   = 5;
  localparam int B_PSAVE    = 4;
  localparam int B_FREQ_HI  = 3;
  localparam int B_FREQ_LO  = 0;
  // fail-safe map field positions
  localparam int B_FS_A0    = 0;
  localparam int B_FS_A1    = 1;
  localparam int B_FS_B0    = 4;
  localparam int B_FS_B1    = 5;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // fault event groups, one bit per device source and one per channel for each output source
  typedef struct packed {
    logic supply_low;
    logic supply_uv;
    logic reference_pin;
    logic thermal_prewarn;
    logic thermal_shutdown;
    logic nvm_checksum;
  } fmd_dev_fault_type;

  typedef struct packed {
    logic [3:0] open_circuit;
    logic [3:0] short_circuit;
    logic [3:0] single_led_short;
  } fmd_out_fault_type;

  // nonvolatile copy of the writable registers
  typedef struct packed {
    logic [7:0] dev_mask;
    logic [7:0] out_mask;
    logic [7:0] dim_cfg;
    logic [7:0] fs_map;
  } fmd_nvm_type;

  typedef struct packed {
    logic       exponential_curve_enable;
    logic       phase_shift_enable;
    logic       twelve_bit_resolution_enable;
    logic       power_save_enable;
    logic [3:0] pwm_frequency_code;
  } fmd_dim_type;

endpackage

// [tb/fmd_config_bank_properties.sv]
/*
  fmd_config_bank_properties: port-level checks of the config bank.
  Assumes binding to fmd_config_bank; reads and writes do not overlap.
*/
`timescale 1ns/1ns
`default_nettype none
module fmd_config_bank_properties (
  // clock, reset and register bus
  input wire logic                        i_mclk,
  input wire logic                        i_resetn,
  input wire logic                        i_awvalid,
  input wire logic                        o_awready,
  input wire logic [fmd_pkg::ADDR_W-1:0]  i_awaddr,
  input wire logic                        i_wvalid,
  input wire logic                        o_wready,
  input wire logic [31:0]                 i_wdata,
  input wire logic [3:0]                  i_wstrb,
  input wire logic                        o_bvalid,
  input wire logic [fmd_pkg::ADDR_W-1:0]  i_araddr,
  input wire logic                        o_rvalid,
  input wire logic [31:0]                 o_rdata,
  input wire logic [1:0]                  o_rresp,
  // reports, dimming and fail-safe
  input wire fmd_pkg::fmd_dev_fault_type  i_dev_fault,
  input wire fmd_pkg::fmd_out_fault_type  i_out_fault,
  input wire fmd_pkg::fmd_dev_fault_type  o_dev_report,
  input wire fmd_pkg::fmd_out_fault_type  o_out_report,
  input wire fmd_pkg::fmd_dim_type        o_dim,
  input wire logic                        i_failsafe_state,
  input wire logic                        o_group_a_output_0,
  input wire logic                        o_group_a_output_1,
  input wire logic                        o_group_b_output_0,
  input wire logic                        o_group_b_output_1
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_resetn);

  // a read answer shows the register as it stood before a landing write
  sequence s_rd(logic [9:0] a);
    $rose(o_rvalid) && $past(i_araddr) == a && !$rose(o_bvalid);
  endsequence
  property p_dev_read;
    s_rd(10'h1f0) |-> o_rdata[1:0] == 2'b00 &&
      o_dev_report == (i_dev_fault & ~o_rdata[7:2]);
  endproperty
  a_dev_read: assert property (p_dev_read)
    else $error("device report disagrees with mask");
  property p_out_read;
    s_rd(10'h1f4) |-> o_rdata[7:3] == 5'h00 && o_out_report == (i_out_fault
      & ~{{4{o_rdata[2]}}, {4{o_rdata[1]}}, {4{o_rdata[0]}}});
  endproperty
  a_out_read: assert property (p_out_read)
    else $error("output report disagrees with mask");
  property p_dim_read;
    s_rd(10'h1f8) |-> o_dim == o_rdata[7:0] && o_rdata[31:8] == 24'h00_0000;
  endproperty
  a_dim_read: assert property (p_dim_read)
    else $error("dimming outputs disagree with register");
  property p_rsvd_read;
    s_rd(10'h1fc) |-> o_rdata == 32'h0000_0000 && o_rresp == 2'b00;
  endproperty
  a_rsvd_read: assert property (p_rsvd_read)
    else $error("reserved register not zero");
  property p_fs_read;
    s_rd(10'h200) |-> o_rdata[7:6] == 2'b00 && o_rdata[3:2] == 2'b00;
  endproperty
  a_fs_read: assert property (p_fs_read)
    else $error("fail-safe map reserved bits set");
  property p_wr_resp;
    i_awvalid && o_awready && i_wvalid && o_wready |-> ##[1:2] o_bvalid;
  endproperty
  a_wr_resp: assert property (p_wr_resp)
    else $error("write response late");
  property p_dim_write;
    i_awvalid && o_awready && i_awaddr == 10'h1f8 && i_wvalid && o_wready
      && i_wstrb[0] |-> ##2 o_dim == $past(i_wdata[7:0], 2);
  endproperty
  a_dim_write: assert property (p_dim_write)
    else $error("dimming write not applied");
  property p_fs_off;
    !$past(i_failsafe_state, 2) |-> !(o_group_a_output_0 ||
      o_group_a_output_1 || o_group_b_output_0 || o_group_b_output_1);
  endproperty
  a_fs_off: assert property (p_fs_off)
    else $error("fail-safe output high outside fail-safe state");
endmodule
`default_nettype wire

// [tb/fmd_config_bank_tb.sv]
/*
  fmd_config_bank_tb: self-checking bench for the config bank.
  Assumes AXI4-Lite answers in any number of cycles and a stable nvm copy.
*/
`timescale 1ns/1ns
`default_nettype none
module fmd_config_bank_tb;
  typedef struct {
    logic [9:0]  a;
    logic [31:0] d;
    logic [3:0]  s;
    logic [31:0] e;
  } fmd_row_type;
  logic                       i_mclk, i_resetn, i_awvalid, i_wvalid;
  logic                       i_bready, i_arvalid, i_rready;
  logic                       i_failsafe_state;
  logic                       i_failsafe_input_0, i_failsafe_input_1;
  logic                       o_awready, o_wready, o_bvalid, o_arready;
  logic                       o_rvalid, o_group_a_output_0;
  logic                       o_group_a_output_1, o_group_b_output_0;
  logic                       o_group_b_output_1;
  logic [9:0]                 i_awaddr, i_araddr;
  logic [2:0]                 i_awprot, i_arprot;
  logic [3:0]                 i_wstrb;
  logic [31:0]                i_wdata, o_rdata, d;
  logic [1:0]                 o_bresp, o_rresp, r;
  fmd_pkg::fmd_nvm_type       i_nvm;
  fmd_pkg::fmd_dev_fault_type i_dev_fault, o_dev_report;
  fmd_pkg::fmd_out_fault_type i_out_fault, o_out_report;
  fmd_pkg::fmd_dim_type       o_dim;
  int                         fails, checks_done;
  wire logic [3:0]            fs_out = {o_group_a_output_0,
    o_group_a_output_1, o_group_b_output_0, o_group_b_output_1};
  fmd_row_type rows [7] = '{
    '{10'h1f0, 32'hffff_ffff, 4'hf, 32'h0000_00fc},
    '{10'h1f0, 32'h0000_0000, 4'hf, 32'h0000_0000},
    '{10'h1f4, 32'hffff_ffff, 4'hf, 32'h0000_0007},
    '{10'h1f8, 32'h0000_005a, 4'h1, 32'h0000_005a},
    '{10'h1f8, 32'h0000_00ff, 4'h0, 32'h0000_005a},
    '{10'h1fc, 32'h0000_00ff, 4'hf, 32'h0000_0000},
    '{10'h200, 32'h0000_00ff, 4'hf, 32'h0000_0033}};
  logic [31:0] rst_exp [2][5] = '{
    '{32'h0000_00fc, 32'h0000_0007, 32'h0000_00a5, 32'h0, 32'h0000_0033},
    '{32'h0000_0000, 32'h0000_0000, 32'h0000_005a, 32'h0, 32'h0000_0000}};

  fmd_config_bank i_fmd_config_bank (.*);

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [9:0] a, input logic [31:0] dd,
                    input logic [3:0] s);
    bit pa, pw, pb, ta, tw, tb;
    @(posedge i_mclk);
    i_awvalid <= 1'b1;
    i_awaddr  <= a;
    i_wvalid  <= 1'b1;
    i_wdata   <= dd;
    i_wstrb   <= s;
    {pa, pw, pb} = 3'b111;
    while (pa || pw || pb) begin
      @(negedge i_mclk);
      ta = pa && o_awready;
      tw = pw && o_wready;
      tb = pb && o_bvalid;
      if (tb) r = o_bresp;
      @(posedge i_mclk);
      {pa, pw, pb} = {pa && !ta, pw && !tw, pb && !tb};
      i_awvalid <= pa;
      i_wvalid  <= pw;
    end
  endtask

  task automatic rchk(input logic [9:0] a, input logic [31:0] e,
                      input logic [1:0] er);
    logic [31:0] rd;
    logic [1:0]  rr;
    bit          pa, pr, ta;
    @(posedge i_mclk);
    i_arvalid <= 1'b1;
    i_araddr  <= a;
    {pa, pr} = 2'b11;
    while (pa || pr) begin
      @(negedge i_mclk);
      ta = pa && o_arready;
      if (!pa && o_rvalid) begin
        rd = o_rdata;
        rr = o_rresp;
        pr = 1'b0;
      end
      @(posedge i_mclk);
      pa = pa && !ta;
      i_arvalid <= pa;
    end
    chk(rd, e);
    chk(32'(rr), 32'(er));
  endtask

  task automatic do_reset;
    i_resetn <= 1'b0;
    repeat (8) @(posedge i_mclk);
    i_resetn <= 1'b1;
  endtask

  task automatic end_sim;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial begin
    i_mclk = 1'b0;
    forever #50 i_mclk = ~i_mclk;
  end

  initial begin
    repeat (3000) @(posedge i_mclk);
    fails++;
    end_sim;
  end

  initial begin
    {i_awvalid, i_wvalid, i_arvalid, i_failsafe_state} = '0;
    {i_failsafe_input_0, i_failsafe_input_1, i_awprot, i_arprot} = '0;
    {i_awaddr, i_araddr, i_wdata, i_wstrb} = '0;
    {i_bready, i_rready} = 2'b11;
    i_dev_fault = '1;
    i_out_fault = '1;
    i_nvm = 32'hffff_a5ff;
    do_reset;
    for (int i = 0; i < 5; i++)
      rchk(10'h1f0 + 10'(4 * i), rst_exp[0][i], 2'b00);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d, rows[i].s);
      chk(32'(r), 32'h0000_0000);
      rchk(rows[i].a, rows[i].e, 2'b00);
    end
    rchk(10'h100, 32'h0000_0000, fmd_pkg::RESP_SLVERR);
    wr(10'h100, 32'h0000_00ff, 4'hf);
    chk(32'(r), 32'(fmd_pkg::RESP_SLVERR));
    for (int i = 0; i < 2; i++) begin
      wr(10'h1f0, i ? 32'h0000_0054 : 32'h0000_00a8, 4'h1);
      wr(10'h1f4, i ? 32'h0000_0002 : 32'h0000_0005, 4'h1);
      @(negedge i_mclk);
      d = i ? 32'h0000_002a : 32'h0000_0015;
      chk(32'(o_dev_report), d);
      d = i ? 32'h0000_0f0f : 32'h0000_00f0;
      chk(32'(o_out_report), d);
    end
    for (int c = 0; c < 16; c++) begin
      wr(10'h1f8, 32'(c * 17), 4'h1);
      @(negedge i_mclk);
      chk(32'(o_dim), 32'(c * 17));
    end
    // map: group a ch0 and group b ch1 on input 1, the others on input 0
    wr(10'h200, 32'h0000_0021, 4'h1);
    for (int v = 0; v < 2; v++) begin
      @(posedge i_mclk);
      i_failsafe_state <= 1'b1;
      i_failsafe_input_0 <= v[0];
      i_failsafe_input_1 <= !v[0];
      repeat (4) @(posedge i_mclk);
      @(negedge i_mclk);
      chk(32'(fs_out), v ? 32'h0000_0006 : 32'h0000_0009);
    end
    @(posedge i_mclk);
    i_failsafe_state <= 1'b0;
    repeat (3) @(posedge i_mclk);
    @(negedge i_mclk);
    chk(32'(fs_out), 32'h0000_0000);
    @(posedge i_mclk);
    i_nvm <= 32'h03f8_5acc;
    do_reset;
    for (int i = 0; i < 5; i++)
      rchk(10'h1f0 + 10'(4 * i), rst_exp[1][i], 2'b00);
    end_sim;
  end
endmodule

bind fmd_config_bank fmd_config_bank_properties i_fmd_config_bank_properties (.*);
`default_nettype wire
